// ---- hw/rcr_config_regs.sv ----
// receiver configuration register bank with its decoded controls
`timescale 1ns/10ps
`include "rcr_params.svh"

module rcr_config_regs (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  // register port from the management interface
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic                 reg_wr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_rd_in,
  output logic      [7:0]           reg_rdata_out,
  output logic                      reg_rvalid_out,
  // neighbouring equalizer registers and live state
  input  wire logic [7:0]           eq_boost_value_in,
  input  wire logic [7:0]           low_rate_boost_in,
  input  wire logic [7:0]           adapt_boost_in,
  input  wire logic                 equalizer_power_down_in,
  // decoded controls
  output rcr_pkg::rcr_detect_s      input_zero_detect_out,
  output rcr_pkg::rcr_detect_s      input_one_detect_out,
  output rcr_pkg::rcr_route_s       route_out,
  output rcr_pkg::rcr_eq_s          eq_out
);

  // stored registers
  logic [7:0] input0_detect_threshold;
  logic [7:0] input1_detect_threshold;
  logic [7:0] eq_boost_override_ctrl;
  logic [7:0] eq_mode_and_routing;
  logic [7:0] next_input0_detect_threshold;
  logic [7:0] next_input1_detect_threshold;
  logic [7:0] next_eq_boost_override_ctrl;
  logic [7:0] next_eq_mode_and_routing;

  // read port state
  logic [7:0] next_reg_rdata;
  logic       next_reg_rvalid;

  // decoded state
  rcr_pkg::rcr_detect_s next_input_zero_detect;
  rcr_pkg::rcr_detect_s next_input_one_detect;
  rcr_pkg::rcr_route_s  next_route;
  rcr_pkg::rcr_eq_s     next_eq;
  logic [1:0]           mode_field;
  logic [1:0]           route_field;
  logic [3:0]           wr_select;
  logic [3:0]           rd_select;

  // offset to one-hot register select, shared by write and read decode
  // unmapped offsets give an all-zero select
  function automatic logic [3:0] reg_select(input logic [7:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    case (addr)
      `RCR_ADDR_INPUT0_THR: sel = 4'h1;
      `RCR_ADDR_INPUT1_THR: sel = 4'h2;
      `RCR_ADDR_OVERRIDE:   sel = 4'h4;
      `RCR_ADDR_MODE_ROUTE: sel = 4'h8;
      default:              sel = 4'h0;
    endcase
    return sel;
  endfunction

  // threshold register to level, same layout for both inputs
  function automatic rcr_pkg::rcr_detect_s decode_detect(input logic [7:0] thr);
    rcr_pkg::rcr_detect_s d;
    d.assert_level   = thr[`RCR_ASSERT_HI:`RCR_ASSERT_LO];
    d.deassert_level = thr[`RCR_DEASSERT_HI:`RCR_DEASSERT_LO];
    case (thr[`RCR_THR_HI:`RCR_THR_LO])
      `RCR_THR_NOMINAL:   d.level = rcr_pkg::RCR_LVL_NOMINAL;
      `RCR_THR_MINUS_2MV: d.level = rcr_pkg::RCR_LVL_MINUS_2MV;
      `RCR_THR_PLUS_5MV:  d.level = rcr_pkg::RCR_LVL_PLUS_5MV;
      `RCR_THR_PLUS_3MV:  d.level = rcr_pkg::RCR_LVL_PLUS_3MV;
      default:            d.level = rcr_pkg::RCR_LVL_UNDEFINED;
    endcase
    return d;
  endfunction

  // register writes, whole byte stored so reserved bits read back
  always_comb begin
    next_input0_detect_threshold = input0_detect_threshold;
    next_input1_detect_threshold = input1_detect_threshold;
    next_eq_boost_override_ctrl  = eq_boost_override_ctrl;
    next_eq_mode_and_routing     = eq_mode_and_routing;
    wr_select = reg_select(reg_addr_in) & {4{reg_wr_in}};
    // a held strobe rewrites the same byte, which is harmless
    if (wr_select[0]) begin
      next_input0_detect_threshold = reg_wdata_in;
    end
    if (wr_select[1]) begin
      next_input1_detect_threshold = reg_wdata_in;
    end
    if (wr_select[2]) begin
      next_eq_boost_override_ctrl  = reg_wdata_in;
    end
    if (wr_select[3]) begin
      next_eq_mode_and_routing     = reg_wdata_in;
    end
  end

  // register storage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      input0_detect_threshold <= `RCR_RST_INPUT0_THR;
      input1_detect_threshold <= `RCR_RST_INPUT1_THR;
      eq_boost_override_ctrl  <= `RCR_RST_OVERRIDE;
      eq_mode_and_routing     <= `RCR_RST_MODE_ROUTE;
    end else begin
      input0_detect_threshold <= next_input0_detect_threshold;
      input1_detect_threshold <= next_input1_detect_threshold;
      eq_boost_override_ctrl  <= next_eq_boost_override_ctrl;
      eq_mode_and_routing     <= next_eq_mode_and_routing;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    next_reg_rvalid = reg_rd_in;
    next_reg_rdata  = reg_rdata_out;
    rd_select       = reg_select(reg_addr_in);
    // a read sees the stored byte, so a write in the same cycle shows next time
    if (reg_rd_in) begin
      // nothing selected leaves zero
      next_reg_rdata = 8'h00;
      if (rd_select[0]) begin
        next_reg_rdata = input0_detect_threshold;
      end
      if (rd_select[1]) begin
        next_reg_rdata = input1_detect_threshold;
      end
      if (rd_select[2]) begin
        next_reg_rdata = eq_boost_override_ctrl;
      end
      if (rd_select[3]) begin
        next_reg_rdata = eq_mode_and_routing;
      end
    end
  end

  // read port registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rdata_out  <= next_reg_rdata;
      reg_rvalid_out <= next_reg_rvalid;
    end
  end

  // signal-detect threshold decode, one function for both inputs
  // patterns other than the four listed ones decode as undefined
  always_comb begin
    next_input_zero_detect = decode_detect(input0_detect_threshold);
    next_input_one_detect  = decode_detect(input1_detect_threshold);
  end

  // signal-detect control registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      input_zero_detect_out <= '{2'h0, 2'h0, rcr_pkg::RCR_LVL_NOMINAL};
      input_one_detect_out  <= '{2'h0, 2'h0, rcr_pkg::RCR_LVL_NOMINAL};
    end else begin
      input_zero_detect_out <= next_input_zero_detect;
      input_one_detect_out  <= next_input_one_detect;
    end
  end

  // routing select to active input and driven outputs
  always_comb begin
    route_field = eq_mode_and_routing[`RCR_ROUTE_HI:`RCR_ROUTE_LO];
    case (route_field)
      `RCR_ROUTE_IN0_BOTH: next_route = '{1'b0, 1'b1, 1'b1};
      `RCR_ROUTE_IN0_OUTPUT_ZERO: next_route = '{1'b0, 1'b1, 1'b0};
      `RCR_ROUTE_IN1_OUTPUT_ONE: next_route = '{1'b1, 1'b0, 1'b1};
      default:             next_route = '{1'b1, 1'b1, 1'b1};
    endcase
  end

  // routing control register, reset state matches routing code 00
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      route_out <= '{1'b0, 1'b1, 1'b1};
    end else begin
      route_out <= next_route;
    end
  end

  // equalizer mode, boost source and power-down
  always_comb begin
    mode_field                    = eq_mode_and_routing[`RCR_MODE_HI:`RCR_MODE_LO];
    next_eq.boost_override_enable = eq_boost_override_ctrl[`RCR_OVERRIDE_BIT];
    // invalid mode codes fall back to normal manual operation
    next_eq.test_mode             = (mode_field == `RCR_MODE_TEST);
    // test mode outranks the override, so the fixed setting wins there
    if (next_eq.test_mode) begin
      next_eq.boost = low_rate_boost_in;
    end else if (next_eq.boost_override_enable) begin
      next_eq.boost = eq_boost_value_in;
    end else begin
      // neither set, the live adapted boost passes through
      next_eq.boost = adapt_boost_in;
    end
    // selected input follows the power-down control, the other stays off
    if (next_route.active_input) begin
      next_eq.power_down = {equalizer_power_down_in, 1'b1};
    end else begin
      next_eq.power_down = {1'b1, equalizer_power_down_in};
    end
  end

  // equalizer control register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      eq_out <= '{1'b1, 1'b0, 8'h00, 2'h3};
    end else begin
      eq_out <= next_eq;
    end
  end

endmodule

// ---- shared/rcr_params.svh ----
// constants for the receiver configuration register bank
// How it works
// - input zero assert level bits 5:4, deassert level bits 3:2; zero means nominal.
// - input one decodes alike; 0101 -2 mV, 1010 +5 mV, 1111 +3 mV.
// - override bit 3 high enables equalizer boost override, low disables it.
// - mode bits 6:5: 00 normal manual, 01 test; other codes invalid, never written.
// - routing bits 1:0 pick active input and which outputs are driven.
// - while override is high outside test mode, stage boosts come from the boost value register.
// - test mode forces low-rate fixed boost; normal mode applies main boost register; the code passes adapt_boost_in there unless override is high.
// - equalizer of the unselected input is always powered down.
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// register offsets
`define RCR_ADDR_INPUT0_THR   8'h14
`define RCR_ADDR_INPUT1_THR   8'h15
`define RCR_ADDR_OVERRIDE     8'h2D
`define RCR_ADDR_MODE_ROUTE   8'h31

// reset values
`define RCR_RST_INPUT0_THR    8'h00
`define RCR_RST_INPUT1_THR    8'h00
`define RCR_RST_OVERRIDE      8'h88
`define RCR_RST_MODE_ROUTE    8'h00

// field positions
`define RCR_THR_HI            5
`define RCR_THR_LO            2
`define RCR_ASSERT_HI         5
`define RCR_ASSERT_LO         4
`define RCR_DEASSERT_HI       3
`define RCR_DEASSERT_LO       2
`define RCR_OVERRIDE_BIT      3
`define RCR_MODE_HI           6
`define RCR_MODE_LO           5
`define RCR_ROUTE_HI          1
`define RCR_ROUTE_LO          0

// field encodings
`define RCR_THR_NOMINAL       4'h0
`define RCR_THR_MINUS_2MV     4'h5
`define RCR_THR_PLUS_5MV      4'hA
`define RCR_THR_PLUS_3MV      4'hF
`define RCR_MODE_NORMAL       2'h0
`define RCR_MODE_TEST         2'h1
`define RCR_ROUTE_IN0_BOTH    2'h0
`define RCR_ROUTE_IN0_OUTPUT_ZERO    2'h1
`define RCR_ROUTE_IN1_OUTPUT_ONE    2'h2
`define RCR_ROUTE_IN1_BOTH    2'h3

`endif

// ---- shared/rcr_pkg.sv ----
// types shared by the receiver configuration register bank
package rcr_pkg;

  // decoded signal-detect threshold setting
  typedef enum logic [2:0] {
    RCR_LVL_NOMINAL,
    RCR_LVL_MINUS_2MV,
    RCR_LVL_PLUS_5MV,
    RCR_LVL_PLUS_3MV,
    RCR_LVL_UNDEFINED
  } rcr_level_e;

  // per-input signal-detect settings
  typedef struct packed {
    logic [1:0] assert_level;
    logic [1:0] deassert_level;
    rcr_level_e level;
  } rcr_detect_s;

  // input and output routing
  typedef struct packed {
    logic active_input;
    logic output_zero_en;
    logic output_one_en;
  } rcr_route_s;

  // equalizer control
  typedef struct packed {
    logic       boost_override_enable;
    logic       test_mode;
    logic [7:0] boost;
    logic [1:0] power_down;
  } rcr_eq_s;

endpackage

// ---- test/rcr_regs_chk.sv ----
// assertions for the receiver configuration register bank
`timescale 1ns/10ps
module rcr_regs_chk (
  // clock, reset and register port
  input wire logic            clk_in,
  input wire logic            rst_b_in,
  input wire logic [7:0]      reg_addr_in,
  input wire logic            reg_wr_in,
  input wire logic [7:0]      reg_wdata_in,
  input wire logic            reg_rd_in,
  input wire logic            reg_rvalid_out,
  // equalizer inputs
  input wire logic [7:0]      eq_boost_value_in,
  input wire logic [7:0]      low_rate_boost_in,
  input wire logic [7:0]      adapt_boost_in,
  input wire logic            equalizer_power_down_in,
  // decoded controls
  input rcr_pkg::rcr_detect_s input_one_detect_out,
  input rcr_pkg::rcr_route_s  route_out,
  input rcr_pkg::rcr_eq_s     eq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // one write to a given register
  sequence wr_at(a);
    reg_wr_in && reg_addr_in == a;
  endsequence
  // read answers one edge after a read, decoded controls two edges after a write
  rd_answer_a: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read lost");
  rd_quiet_a: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray answer");
  ovr_bit_a: assert property (wr_at(8'h2D) |-> ##2
    eq_out.boost_override_enable == $past(reg_wdata_in[3], 2)) else $error("override bit");
  eq_mode_a: assert property (wr_at(8'h31) |-> ##2
    eq_out.test_mode == ($past(reg_wdata_in[6:5], 2) == 2'h1)) else $error("mode");
  route_sel_a: assert property (wr_at(8'h31) |-> ##2 route_out ==
    {$past(reg_wdata_in[1], 2), $past(reg_wdata_in[1:0], 2) != 2'h2, $past(reg_wdata_in[1:0], 2) != 2'h1})
    else $error("routing");
  thr_field_a: assert property (wr_at(8'h15) |-> ##2
    input_one_detect_out[6:3] == $past(reg_wdata_in[5:2], 2)) else $error("threshold");
  eq_power_a: assert property ($past(rst_b_in) |-> eq_out.power_down[!route_out.active_input] &&
    eq_out.power_down[route_out.active_input] == $past(equalizer_power_down_in)) else $error("power down");
  boost_src_a: assert property ($past(rst_b_in) |-> eq_out.boost == (eq_out.test_mode ?
    $past(low_rate_boost_in) : eq_out.boost_override_enable ? $past(eq_boost_value_in) : $past(adapt_boost_in)))
    else $error("boost");
endmodule

bind rcr_config_regs rcr_regs_chk u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rvalid_out(reg_rvalid_out),
  .eq_boost_value_in(eq_boost_value_in), .low_rate_boost_in(low_rate_boost_in), .adapt_boost_in(adapt_boost_in),
  .equalizer_power_down_in(equalizer_power_down_in), .input_one_detect_out(input_one_detect_out),
  .route_out(route_out), .eq_out(eq_out));

// ---- test/tb.sv ----
// self-checking bench for the receiver configuration register bank
`timescale 1ns/10ps
module tb;
  logic clk_in = 1'b0, rst_b_in = 1'b0, we = 1'b0, re = 1'b0, pdn = 1'b0, rv;
  logic [7:0] a = 8'h00, wd = 8'h00, bv = 8'h00, lr = 8'h00, ad = 8'h00, rd, d;
  rcr_pkg::rcr_detect_s d0, d1;
  rcr_pkg::rcr_route_s rt;
  rcr_pkg::rcr_eq_s eq;
  logic [7:0] mdl [5];
  logic [7:0] adr [5] = '{8'h14, 8'h15, 8'h2D, 8'h31, 8'h5C};
  int miscompares = 0, cmp_count = 0, k;
  // free-running clock
  always #2.5 clk_in = ~clk_in;
  rcr_config_regs dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(a), .reg_wr_in(we),
    .reg_wdata_in(wd), .reg_rd_in(re), .reg_rdata_out(rd), .reg_rvalid_out(rv), .eq_boost_value_in(bv),
    .low_rate_boost_in(lr), .adapt_boost_in(ad), .equalizer_power_down_in(pdn),
    .input_zero_detect_out(d0), .input_one_detect_out(d1), .route_out(rt), .eq_out(eq));
  // expected threshold decode
  function automatic rcr_pkg::rcr_level_e lvl(input logic [7:0] v);
    case (v[5:2])
      4'h0: return rcr_pkg::RCR_LVL_NOMINAL;
      4'h5: return rcr_pkg::RCR_LVL_MINUS_2MV;
      4'hA: return rcr_pkg::RCR_LVL_PLUS_5MV;
      4'hF: return rcr_pkg::RCR_LVL_PLUS_3MV;
      default: return rcr_pkg::RCR_LVL_UNDEFINED;
    endcase
  endfunction
  // one comparison
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // optional write, read back, then compare every decoded output
  task automatic step(input int i, input logic [7:0] v, input logic w);
    logic [1:0] r;
    logic tm;
    @(posedge clk_in);
    a <= adr[i];
    wd <= v;
    we <= w;
    bv <= 8'($urandom_range(255));
    lr <= 8'($urandom_range(255));
    ad <= 8'($urandom_range(255));
    pdn <= 1'($urandom_range(1));
    if (w && i < 4) mdl[i] = v;
    @(posedge clk_in);
    we <= 1'b0;
    re <= 1'b1;
    @(posedge clk_in);
    re <= 1'b0;
    #1;
    r = mdl[3][1:0];
    tm = mdl[3][6:5] == 2'h1;
    chk("rdata", mdl[i], rd);
    chk("rvalid", 16'h0001, {15'h0000, rv});
    chk("detect0", {mdl[0][5:2], lvl(mdl[0])}, d0);
    chk("detect1", {mdl[1][5:2], lvl(mdl[1])}, d1);
    chk("route", {r[1], r != 2'h2, r != 2'h1}, rt);
    chk("eq", {mdl[2][3], tm, tm ? lr : (mdl[2][3] ? bv : ad),
      r[1] ? {pdn, 1'b1} : {1'b1, pdn}}, eq);
  endtask
  // reset, then read every reset value and the unmapped place
  task automatic reset_dut();
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    mdl = '{8'h00, 8'h00, 8'h88, 8'h00, 8'h00};
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 5; i++) step(i, 8'h00, 1'b0);
  endtask
  // verdict and end of run
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // directed patterns, then random writes including the unmapped place
  initial begin
    void'($urandom(96697));
    reset_dut();
    for (int n = 0; n < 60; n++) begin
      k = (n < 16) ? n % 4 : $urandom_range(4);
      d = (n < 16) ? 8'(8'h55 * (n / 4)) : 8'($urandom_range(255));
      if (k == 3) d[6] = 1'b0;
      step(k, d, 1'b1);
    end
    reset_dut();
    wrap_up();
  end
  // watchdog against a hang
  initial begin
    repeat (1000) @(posedge clk_in);
    miscompares++;
    wrap_up();
  end
endmodule
